/* core/external_wait_state_generator.sv */
// Summary of operation
// R1: each 3-bit wait field is a plain binary count giving 0 to 7 wait states.
// R2: bits 2-0 set the waits for external lower program space, addresses 0 to 7fffh.
// R3: bits 5-3 set the waits for external upper program space, from 8000h upward.
// R4: bits 8-6 set the waits for every external data space access.
// R5: bits 11-9 set the waits for every external i/o space access.
// R6: ready held low may lengthen an access, but the programmed waits are always inserted.
// R7: reset sets every bit of all four wait fields to one.
// R8: the configuration register is reached as i/o port fffch.
// R9: wait states are counted in whole machine cycles, on cycle boundaries.
// R10: an access is stretched without limit while ready stays low.
// R11: the four unused upper bits of the configuration register read as zero.
// R12: an access ends only after its waits elapse and ready is then sampled high.
module external_wait_state_generator (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// external ready pin
	input wire logic ready_in,
	// access request from the core
	input wire logic access_req_in,
	input wire logic [1:0] access_space_in,
	input wire logic [15:0] access_addr_in,
	// i/o port access from the core
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [15:0] io_wdata_in,
	// access status
	output logic access_done_out,
	output logic wait_active_out,
	// i/o read data and configuration
	output logic [15:0] io_rdata_out,
	output logic [11:0] wait_config_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [wait_gen_pkg::CFG_W-1:0] cfg;
		wait_gen_pkg::seq_state_t state;
		logic ready_meta;
		logic ready_sync;
		logic done;
		logic busy;
		logic [15:0] rdata;
	} gen_state_t;

	gen_state_t st_reg;
	gen_state_t st_next;

	logic cfg_hit;
	logic start;
	logic [wait_gen_pkg::FIELD_W-1:0] field_sel;
	logic [wait_gen_pkg::FIELD_W-1:0] count;
	logic count_zero;
	logic step;

	assign cfg_hit = (io_addr_in == wait_gen_pkg::CFG_PORT_ADDR); // R8
	assign start = access_req_in && (st_reg.state == wait_gen_pkg::ST_IDLE);
	assign step = (st_reg.state == wait_gen_pkg::ST_WAIT);

	// ------------------------------------------------------------
	// field selection by space
	// ------------------------------------------------------------

	// pick the wait field of the addressed space
	always_comb
	begin
		field_sel = st_reg.cfg[wait_gen_pkg::IO_LSB +: wait_gen_pkg::FIELD_W]; // R5
		unique case (access_space_in)
			wait_gen_pkg::SPACE_PROG:
			begin
				if (access_addr_in[wait_gen_pkg::UPPER_PROG_BIT])
				begin
					field_sel = st_reg.cfg[wait_gen_pkg::HIGH_PROG_LSB +: wait_gen_pkg::FIELD_W]; // R3
				end
				else
				begin
					field_sel = st_reg.cfg[wait_gen_pkg::LOW_PROG_LSB +: wait_gen_pkg::FIELD_W]; // R2
				end
			end
			wait_gen_pkg::SPACE_DATA:
			begin
				field_sel = st_reg.cfg[wait_gen_pkg::DATA_LSB +: wait_gen_pkg::FIELD_W]; // R4
			end
			default:
			begin
				field_sel = st_reg.cfg[wait_gen_pkg::IO_LSB +: wait_gen_pkg::FIELD_W]; // R5
			end
		endcase
	end

	// ------------------------------------------------------------
	// wait counter
	// ------------------------------------------------------------

	// binary down count, one per machine cycle
	wait_count_timer #(
		.WIDTH(wait_gen_pkg::FIELD_W)
	) u_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.load_in(start), // R1
		.load_value_in(field_sel),
		.step_in(step),
		.count_out(count),
		.zero_out(count_zero)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------

	// config write, read data, ready sync and sequencer
	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.ready_meta = ready_in;
		st_next.ready_sync = st_reg.ready_meta;
		if (io_wr_in && cfg_hit)
		begin
			st_next.cfg = io_wdata_in[wait_gen_pkg::CFG_W-1:0]; // R8
		end
		if (io_rd_in && cfg_hit)
		begin
			st_next.rdata = {4'h0, st_reg.cfg}; // R11
		end
		else if (io_rd_in)
		begin
			st_next.rdata = 16'h0000; // unmapped port
		end
		unique case (st_reg.state)
			wait_gen_pkg::ST_IDLE:
			begin
				if (start)
				begin
					st_next.state = wait_gen_pkg::ST_WAIT;
				end
			end
			wait_gen_pkg::ST_WAIT:
			begin
				// waits first, then ready, both on cycle boundaries
				if (count_zero && st_reg.ready_sync) // R12 R6
				begin
					st_next.done = 1'b1;
					st_next.state = wait_gen_pkg::ST_IDLE;
				end
				// ready low keeps the access open indefinitely, R10
			end
			default:
			begin
				st_next.state = wait_gen_pkg::ST_IDLE;
			end
		endcase
		// busy flag registered so the status pin comes from a flop
		st_next.busy = (st_next.state == wait_gen_pkg::ST_WAIT); // R12
	end

	// state register
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_reg.cfg <= wait_gen_pkg::CFG_RESET; // R7
			st_reg.state <= wait_gen_pkg::ST_IDLE;
			st_reg.ready_meta <= 1'b0;
			st_reg.ready_sync <= 1'b0;
			st_reg.done <= 1'b0;
			st_reg.busy <= 1'b0;
			st_reg.rdata <= 16'h0000;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign access_done_out = st_reg.done;
	assign wait_active_out = st_reg.busy;
	assign io_rdata_out = st_reg.rdata;
	assign wait_config_out = st_reg.cfg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	// config comes out of reset at all ones
	a_cfg_reset_ones: assert property (@(posedge mclk_in) // R7
		$rose(rst_n_in) |-> (wait_config_out == 12'hfff))
		else $error("config not all ones after reset");

	// write to the config port lands one cycle later
	a_cfg_port_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R8
		(io_wr_in && io_addr_in == 16'hfffc) |=> (wait_config_out == $past(io_wdata_in[11:0])))
		else $error("config port write lost");

	// other ports leave the config alone
	a_cfg_other_port: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R8
		(io_addr_in != 16'hfffc) |=> $stable(wait_config_out))
		else $error("config changed by other port");

	// upper read bits always zero
	a_upper_bits_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R11
		io_rdata_out[15:12] == 4'h0)
		else $error("reserved read bits not zero");

	// lower program space loads its field
	a_low_prog_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R2
		(start && access_space_in == 2'h0 && !access_addr_in[15])
		|=> (count == $past(st_reg.cfg[2:0])))
		else $error("lower program wait count wrong");

	// upper program space loads its field
	a_high_prog_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R3
		(start && access_space_in == 2'h0 && access_addr_in[15])
		|=> (count == $past(st_reg.cfg[5:3])))
		else $error("upper program wait count wrong");

	// data space loads its field
	a_data_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R4
		(start && access_space_in == 2'h1) |=> (count == $past(st_reg.cfg[8:6])))
		else $error("data space wait count wrong");

	// i/o space loads its field
	a_io_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R5
		(start && access_space_in == 2'h2) |=> (count == $past(st_reg.cfg[11:9])))
		else $error("io space wait count wrong");

	// one count per machine cycle
	a_count_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R1 R9
		(wait_active_out && !count_zero) |=> (count == $past(count) - 3'h1))
		else $error("wait count did not step by one");

	// seven waits with ready high end on the ninth edge
	a_seven_waits: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R1
		(start && field_sel == 3'h7) ##1 st_reg.ready_sync[*8] |=> access_done_out)
		else $error("seven wait access timing wrong");

	// done only after waits elapsed and ready seen
	a_done_cause: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R12 R6
		access_done_out |-> ($past(count_zero) && $past(st_reg.ready_sync)))
		else $error("access ended early");

	// ready low holds the access open
	a_ready_stretch: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // R10
		(wait_active_out && !st_reg.ready_sync) |=> (wait_active_out && !access_done_out))
		else $error("access ended while ready low");

endmodule

/* core/wait_count_timer.sv */
module wait_count_timer #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// control
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_value_in,
	input wire logic step_in,
	// state
	output logic [WIDTH-1:0] count_out,
	output logic zero_out
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} timer_t;

	timer_t timer_reg;
	timer_t timer_next;

	// load on a new access, else step down once per machine cycle
	always_comb
	begin
		timer_next = timer_reg;
		if (load_in)
		begin
			timer_next.count = load_value_in;
		end
		else if (step_in && (timer_reg.count != '0))
		begin
			timer_next.count = timer_reg.count - WIDTH'(1); // R9
		end
	end

	// state register
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			timer_reg <= '0;
		end
		else
		begin
			timer_reg <= timer_next;
		end
	end

	assign count_out = timer_reg.count;
	assign zero_out = (timer_reg.count == '0);

endmodule

/* core/wait_gen_pkg.sv */
package wait_gen_pkg;

	// ------------------------------------------------------------
	// register location and layout
	// ------------------------------------------------------------
	localparam logic [15:0] CFG_PORT_ADDR = 16'hfffc; // i/o port of the config register
	localparam int FIELD_W = 3;
	localparam int CFG_W = 12;
	localparam int LOW_PROG_LSB = 0;
	localparam int HIGH_PROG_LSB = 3;
	localparam int DATA_LSB = 6;
	localparam int IO_LSB = 9;
	localparam logic [CFG_W-1:0] CFG_RESET = 12'hfff; // every field at seven waits
	localparam logic [15:0] UPPER_PROG_BASE = 16'h8000;
	localparam int UPPER_PROG_BIT = 15; // address bit that selects upper program space

	// ------------------------------------------------------------
	// external spaces
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPACE_PROG = 2'h0,
		SPACE_DATA = 2'h1,
		SPACE_IO = 2'h2
	} space_t;

	// ------------------------------------------------------------
	// access sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_WAIT = 2'h2
	} seq_state_t;

endpackage

/* dv/external_wait_state_generator_tb.sv */
module external_wait_state_generator_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk_in, rst_n_in, ready, req, io_wr, io_rd, done, busy;
	logic [1:0] space;
	logic [15:0] addr, io_addr, io_wdata, rdata, rd;
	logic [11:0] cfg_out, cfg;
	int stall, errors = 0, n_checks = 0, lat;

	external_wait_state_generator i_external_wait_state_generator (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ready_in(ready),
		.access_req_in(req), .access_space_in(space), .access_addr_in(addr),
		.io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr),
		.io_wdata_in(io_wdata), .access_done_out(done), .wait_active_out(busy),
		.io_rdata_out(rdata), .wait_config_out(cfg_out)
	);

	slow_device_model i_slow_device_model (
		.mclk_in(mclk_in), .busy_in(busy), .stall_in(stall), .ready_out(ready)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one-cycle port write strobe
	task automatic io_write(input logic [15:0] a, input logic [15:0] d);
		io_wr = 1'b1;
		io_addr = a;
		io_wdata = d;
		@(negedge mclk_in);
		io_wr = 1'b0;
		@(negedge mclk_in);
	endtask

	// one-cycle read strobe, data sampled a cycle on
	task automatic io_read(input logic [15:0] a, output logic [15:0] d);
		io_rd = 1'b1;
		io_addr = a;
		@(negedge mclk_in);
		io_rd = 1'b0;
		@(negedge mclk_in);
		d = rdata;
	endtask

	// cycles from taking edge to done edge
	task automatic access(input logic [1:0] s, input logic [15:0] a, output int l);
		int c;
		req = 1'b1;
		space = s;
		addr = a;
		@(negedge mclk_in);
		req = 1'b0;
		c = 1;
		chk(16'(busy), 16'h0001);
		while (done !== 1'b1 && c < 200)
		begin
			@(negedge mclk_in);
			c++;
		end
		chk(16'(busy), 16'h0000);
		l = c - 1;
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial
	begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	initial
	begin
		#(3000 * 100);
		errors++;
		results;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		rst_n_in = 1'b0;
		req = 1'b0;
		space = 2'h0;
		addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 16'h0000;
		stall = 0;
		repeat (8) @(negedge mclk_in);
		rst_n_in = 1'b1;
		chk({4'h0, cfg_out}, 16'h0fff);
		io_read(wait_gen_pkg::CFG_PORT_ADDR, rd);
		chk(rd, 16'h0fff);
		io_write(16'hfffd, 16'h0000);
		chk({4'h0, cfg_out}, 16'h0fff);
		io_read(16'hfffd, rd);
		chk(rd, 16'h0000);
		io_write(wait_gen_pkg::CFG_PORT_ADDR, 16'hf123);
		io_read(wait_gen_pkg::CFG_PORT_ADDR, rd);
		chk(rd, 16'h0123);
		// every field at every count, other fields left at seven
		for (int s = 0; s < 4; s++)
		begin
			for (int n = 0; n < 8; n++)
			begin
				cfg = (12'hfff & ~(12'h7 << (3 * s))) | (12'(n) << (3 * s));
				io_write(wait_gen_pkg::CFG_PORT_ADDR, {4'h0, cfg});
				access(s < 2 ? 2'h0 : 2'(s - 1), s == 1 ? 16'h8000 : 16'h7fff, lat);
				chk(16'(lat), 16'(n + 1));
			end
		end
		// slow device holds ready low well past three programmed waits;
		// the ready synchroniser needs at least two waits to see it low
		stall = 20;
		io_write(wait_gen_pkg::CFG_PORT_ADDR, 16'h00c0);
		access(2'h1, 16'h0100, lat);
		chk(16'(lat >= 21 && lat <= 27), 16'h0001);
		results;
	end
endmodule

/* dv/slow_device_model.sv */
module slow_device_model (
	// clock
	input wire logic mclk_in,
	// access status and stall length
	input wire logic busy_in,
	input wire logic [31:0] stall_in,
	// ready pin
	output logic ready_out
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt = 0;
	logic seen = 1'b0;

	// ready low for stall_in cycles once an access starts
	initial ready_out = 1'b1;
	always @(negedge mclk_in)
	begin
		if (busy_in && !seen)
		begin
			seen = 1'b1;
			cnt = int'(stall_in);
		end
		if (!busy_in)
			seen = 1'b0;
		ready_out <= (cnt == 0);
		if (cnt > 0)
			cnt = cnt - 1;
	end
endmodule
